// ==== hw/dss_pkg.sv ====
// package with operation codes, carriers and constants of the doubleword shift/subtract unit
package dss_pkg;

  // datapath widths
  localparam int DSS_DATA_W = 64;
  localparam int DSS_IDX_W = 5;
  localparam int DSS_SA_W = 5;
  localparam int DSS_CNT_W = 6;
  // sign bit position of a doubleword
  localparam int DSS_SIGN_BIT = 63;
  // values after reset
  localparam logic [63:0] DSS_RESULT_RST = 64'h0;
  localparam logic [4:0] DSS_IDX_RST = 5'h0;

  // one-hot operation select, bit positions
  localparam int DSS_OP_SRA_FIX = 0;
  localparam int DSS_OP_SRA_FIX32 = 1;
  localparam int DSS_OP_SRA_VAR = 2;
  localparam int DSS_OP_SRL_FIX = 3;
  localparam int DSS_OP_SRL_FIX32 = 4;
  localparam int DSS_OP_SRL_VAR = 5;
  localparam int DSS_OP_SUB_TRAP = 6;
  localparam int DSS_OP_SUB_WRAP = 7;
  localparam int DSS_OP_W = 8;

  // one operation as delivered by decode
  typedef struct packed {
    logic [DSS_OP_W-1:0] opSel;
    logic [DSS_IDX_W-1:0] operandAIndex;
    logic [DSS_IDX_W-1:0] operandBIndex;
    logic [DSS_IDX_W-1:0] destIndex;
    logic [DSS_SA_W-1:0] shiftAmountField;
    logic [DSS_DATA_W-1:0] operandA;
    logic [DSS_DATA_W-1:0] operandB;
  } dss_req_t;

  // write-back and exception report
  typedef struct packed {
    logic writeEn;
    logic [DSS_IDX_W-1:0] destIndex;
    logic [DSS_DATA_W-1:0] result;
    logic overflowExc;
    logic reservedExc;
  } dss_resp_t;

endpackage

// ==== hw/dss_shifter.sv ====
// 64-bit right shifter with arithmetic or logical fill
`timescale 1ns/1ns
module dss_shifter #(
  parameter int DATA_W = 64
) (
  // operand and count
  input wire logic [DATA_W-1:0] src,
  input wire logic [$clog2(DATA_W)-1:0] count,
  input wire logic arith,
  // shifted value
  output logic [DATA_W-1:0] result
);
  import dss_pkg::*;

  // a one-bit datapath leaves no room for a count, so refuse it at elaboration
  if (DATA_W < 2) begin : g_width_check
    $error("dss_shifter needs a datapath of at least two bits");
  end

  // fill bit is the sign for arithmetic, zero for logical
  logic fillBit;
  logic [2*DATA_W-1:0] wide;

  // widen with fill copies, then take the low half after shifting
  always_comb begin
    fillBit = arith & src[DATA_W-1];
    wide = {{DATA_W{fillBit}}, src} >> count;
    result = wide[DATA_W-1:0];
  end

endmodule

// ==== hw/dss_unit.sv ====
// doubleword right shift and subtract execution unit, one-cycle registered result
// Functional notes
// - arithmetic right shifts fill with bit 63
// - logical right shifts fill with zeros
// - fixed shifts use the 5-bit amount field
// - plus-32 shifts prefix a one bit
// - variable count uses operand A bits 5..0
// - variable shifts cover counts 0 to 63
// - trapping subtract writes A minus B unless overflow
// - on overflow keep destination, raise overflow exception
// - wrapping subtract always writes, never traps
// - trapping subtract may raise reserved-instruction, no write
`timescale 1ns/1ns
module dss_unit (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // operation from decode
  input wire logic reqValid,
  input wire dss_pkg::dss_req_t req,
  input wire logic reservedInstr,
  // write-back and exceptions
  output dss_pkg::dss_resp_t resp
);
  import dss_pkg::*;

  // signed overflow of a - b: operands differ in sign and result sign follows b
  function automatic logic sub_overflow(input logic [63:0] a, input logic [63:0] b,
                                        input logic [63:0] d);
    sub_overflow = (a[DSS_SIGN_BIT] != b[DSS_SIGN_BIT]) &&
                   (d[DSS_SIGN_BIT] != a[DSS_SIGN_BIT]);
  endfunction

  // shifter controls and output
  logic [DSS_CNT_W-1:0] shiftCount;
  logic shiftArith;
  logic [DSS_DATA_W-1:0] shiftResult;
  // subtract path
  logic [DSS_DATA_W-1:0] diff;
  logic subOvf;
  // registered answer and its next value
  dss_resp_t next_resp;

  // count and fill select; variable count ignores bits above 5 of operand A
  always_comb begin
    shiftCount = '0;
    shiftArith = 1'b0;
    if (req.opSel[DSS_OP_SRA_FIX] || req.opSel[DSS_OP_SRL_FIX]) begin
      shiftCount = {1'b0, req.shiftAmountField};
    end else if (req.opSel[DSS_OP_SRA_FIX32] || req.opSel[DSS_OP_SRL_FIX32]) begin
      shiftCount = {1'b1, req.shiftAmountField};
    end else begin
      shiftCount = req.operandA[DSS_CNT_W-1:0];
    end
    shiftArith = req.opSel[DSS_OP_SRA_FIX] | req.opSel[DSS_OP_SRA_FIX32] |
                 req.opSel[DSS_OP_SRA_VAR];
  end

  // the single shifter serves all six shift forms
  dss_shifter #(
    .DATA_W(DSS_DATA_W)
  ) u_shift (
    .src(req.operandB),
    .count(shiftCount),
    .arith(shiftArith),
    .result(shiftResult)
  );

  // subtract is shared by both forms; only the trap decision differs
  always_comb begin
    diff = req.operandA - req.operandB;
    subOvf = sub_overflow(req.operandA, req.operandB, diff);
  end

  // next answer: write enable, result and exception pulses
  always_comb begin
    next_resp = '0;
    next_resp.destIndex = req.destIndex;
    if (reqValid) begin
      if (req.opSel[DSS_OP_SUB_TRAP]) begin
        // exceptions suppress the write so the destination keeps its value
        if (reservedInstr) begin
          next_resp.reservedExc = 1'b1;
        end else if (subOvf) begin
          next_resp.overflowExc = 1'b1;
        end else begin
          next_resp.writeEn = 1'b1;
          next_resp.result = diff;
        end
      end else if (req.opSel[DSS_OP_SUB_WRAP]) begin
        next_resp.writeEn = 1'b1;
        next_resp.result = diff;
      end else if (|req.opSel[DSS_OP_SRL_VAR:DSS_OP_SRA_FIX]) begin
        next_resp.writeEn = 1'b1;
        next_resp.result = shiftResult;
      end else begin
        // no known select: nothing written
        next_resp.writeEn = 1'b0;
      end
    end
  end

  // register the answer; reset clears every field
  always_ff @(posedge clk) begin
    if (rst) begin
      resp <= '0;
    end else begin
      resp <= next_resp;
    end
  end

  // helper: sign-extended difference for the checks; kept apart from the overflow function
  // so that a fault there cannot hide itself from the assertions below
  logic [DSS_DATA_W:0] chkDiff;
  assign chkDiff = {req.operandA[DSS_SIGN_BIT], req.operandA} -
                   {req.operandB[DSS_SIGN_BIT], req.operandB};

  sra_fill_a: assert property (@(posedge clk) disable iff (rst)
    reqValid && req.opSel[DSS_OP_SRA_FIX32] && req.operandB[63] |=>
      resp.writeEn && resp.result[63:32] == 32'hffffffff)
    else $error("arithmetic plus-32 shift lost sign fill");

  srl_fill_a: assert property (@(posedge clk) disable iff (rst)
    reqValid && req.opSel[DSS_OP_SRL_FIX32] |=> resp.result[63:32] == 32'h0)
    else $error("logical plus-32 shift left upper bits set");

  fixed_count_a: assert property (@(posedge clk) disable iff (rst)
    reqValid && req.opSel[DSS_OP_SRL_FIX] |=>
      resp.result == ($past(req.operandB) >> $past(req.shiftAmountField)))
    else $error("fixed logical shift count wrong");

  plus32_count_a: assert property (@(posedge clk) disable iff (rst)
    reqValid && req.opSel[DSS_OP_SRL_FIX32] |=>
      resp.result == ($past(req.operandB) >> (32 + $past(req.shiftAmountField))))
    else $error("plus-32 shift count wrong");

  var_count_a: assert property (@(posedge clk) disable iff (rst)
    reqValid && req.opSel[DSS_OP_SRL_VAR] |=>
      resp.result == ($past(req.operandB) >> $past(req.operandA[5:0])))
    else $error("variable shift did not use low six bits");

  var_full_a: assert property (@(posedge clk) disable iff (rst)
    reqValid && req.opSel[DSS_OP_SRA_VAR] && req.operandA[5:0] == 6'h3f |=>
      resp.result == {64{$past(req.operandB[63])}})
    else $error("shift by 63 wrong");

  trap_write_a: assert property (@(posedge clk) disable iff (rst)
    reqValid && req.opSel[DSS_OP_SUB_TRAP] && chkDiff[64] == chkDiff[63] && !reservedInstr |=>
      resp.writeEn && resp.result == $past(req.operandA) - $past(req.operandB))
    else $error("trapping subtract did not write difference");

  trap_ovf_a: assert property (@(posedge clk) disable iff (rst)
    reqValid && req.opSel[DSS_OP_SUB_TRAP] && chkDiff[64] != chkDiff[63] && !reservedInstr |=>
      resp.overflowExc && !resp.writeEn)
    else $error("overflow not trapped or destination written");

  wrap_nevertrap_a: assert property (@(posedge clk) disable iff (rst)
    reqValid && req.opSel[DSS_OP_SUB_WRAP] |=> resp.writeEn && !resp.overflowExc)
    else $error("wrapping subtract trapped or skipped write");

  reserved_nowrite_a: assert property (@(posedge clk) disable iff (rst)
    reqValid && req.opSel[DSS_OP_SUB_TRAP] && reservedInstr |=>
      resp.reservedExc && !resp.writeEn && !resp.overflowExc)
    else $error("reserved instruction did not suppress write");

endmodule

// ==== verif/dss_decode_model.sv ====
// decode-stage model that hands one operation a cycle to the unit
`timescale 1ns/1ns
module dss_decode_model (
  // clock
  input wire logic clk,
  // operation to present next
  input wire logic issue,
  input wire logic rsvIn,
  input wire dss_pkg::dss_req_t nextReq,
  // towards the unit
  output logic reqValid,
  output logic reservedInstr,
  output dss_pkg::dss_req_t req
);
  import dss_pkg::*;
  // every field launches on one edge; idle fields are inverted so stale data never looks valid
  always_ff @(posedge clk) begin
    reqValid <= issue;
    reservedInstr <= issue ? rsvIn : ~reservedInstr;
    req <= issue ? nextReq : ~req;
  end
endmodule

// ==== verif/dss_unit_tb.sv ====
// self-checking bench of the doubleword shift and subtract unit
`timescale 1ns/1ns
module dss_unit_tb;
  import dss_pkg::*;
  // table row: operation (8 means none), operands, amount field, reserved flag
  typedef struct {int op; logic [63:0] a; logic [63:0] b; logic [4:0] amt; logic rsv;} dss_row_t;
  localparam int N = 13;
  localparam int W = $bits(dss_resp_t);
  localparam logic [63:0] MSB = 64'h8000_0000_0000_0000;
  localparam logic [63:0] ONES = 64'hffff_ffff_ffff_ffff;
  typedef logic [W-1:0] dss_word_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic issue = 1'b0;
  logic rsvIn = 1'b0;
  logic reqValid;
  logic reservedInstr;
  dss_req_t nextReq = '0;
  dss_req_t req;
  dss_resp_t resp;
  int errors = 0;
  int num_checks = 0;
  dss_row_t rows [N];
  // expected answer while decode idles: its first idle cycle presents the complement of its last request, then toggles back
  dss_resp_t idleResp;

  dss_decode_model u_dss_decode_model (.clk(clk), .issue(issue), .rsvIn(rsvIn),
    .nextReq(nextReq), .reqValid(reqValid), .reservedInstr(reservedInstr), .req(req));
  dss_unit u_dss_unit (.clk(clk), .rst(rst), .reqValid(reqValid), .req(req),
    .reservedInstr(reservedInstr), .resp(resp));

  // 8 ns period
  initial begin
    forever #4 clk = ~clk;
  end

  // expected answer worked out from the operands alone
  function automatic dss_resp_t expect_of(dss_row_t r, int d);
    dss_resp_t e;
    logic [63:0] diff;
    e = '0;
    diff = r.a - r.b;
    e.destIndex = 5'(d);
    e.writeEn = (r.op < 8);
    case (r.op)
      0: e.result = $signed(r.b) >>> r.amt;
      1: e.result = $signed(r.b) >>> (r.amt + 32);
      2: e.result = $signed(r.b) >>> r.a[5:0];
      3: e.result = r.b >> r.amt;
      4: e.result = r.b >> (r.amt + 32);
      5: e.result = r.b >> r.a[5:0];
      6, 7: e.result = diff;
      default: e.result = '0;
    endcase
    e.reservedExc = (r.op == 6) && r.rsv;
    e.overflowExc = (r.op == 6) && !r.rsv && (r.a[63] != r.b[63]) && (diff[63] != r.a[63]);
    if (r.op == 6) e.writeEn = !e.reservedExc && !e.overflowExc;
    return e;
  endfunction

  // write enable, exceptions and result; the echoed index is left out
  function automatic dss_word_t flags_of(dss_resp_t r);
    return W'({r.writeEn, r.overflowExc, r.reservedExc, r.result});
  endfunction

  task automatic chk(string name, dss_word_t seen, dss_word_t exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic drive(dss_row_t r, int d);
    dss_req_t q;
    q = '0;
    if (r.op < 8) q.opSel[r.op] = 1'b1;
    q.operandAIndex = 5'(d + 1);
    q.operandBIndex = 5'(d + 2);
    q.destIndex = 5'(d);
    q.shiftAmountField = r.amt;
    q.operandA = r.a;
    q.operandB = r.b;
    issue <= 1'b1;
    rsvIn <= r.rsv;
    nextReq <= q;
  endtask

  // result only matters when a write is expected
  task automatic cmp(dss_row_t r, int d);
    dss_resp_t e;
    e = expect_of(r, d);
    chk("writeEn", W'(resp.writeEn), W'(e.writeEn));
    if (e.writeEn) begin
      case (r.op)
        0: chk("sra fixed", W'(resp.result), W'(e.result));
        1: chk("sra plus32", W'(resp.result), W'(e.result));
        2: chk("sra variable", W'(resp.result), W'(e.result));
        3: chk("srl fixed", W'(resp.result), W'(e.result));
        4: chk("srl plus32", W'(resp.result), W'(e.result));
        5: chk("srl variable", W'(resp.result), W'(e.result));
        6: chk("sub trap", W'(resp.result), W'(e.result));
        default: chk("sub wrap", W'(resp.result), W'(e.result));
      endcase
    end
    chk("overflowExc", W'(resp.overflowExc), W'(e.overflowExc));
    chk("reservedExc", W'(resp.reservedExc), W'(e.reservedExc));
    chk("destIndex", W'(resp.destIndex), W'(e.destIndex));
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // a hang counts as a mismatch
  initial begin
    repeat (200) @(posedge clk);
    errors++;
    stop_test();
  end

  initial begin
    rows = '{'{0, 0, MSB, 31, 0}, '{1, 0, MSB, 31, 0}, '{2, ONES, MSB, 0, 0},
      '{3, 0, ONES, 0, 0}, '{4, 0, ONES, 31, 0}, '{5, 64'h40, ONES, 0, 0},
      '{2, 64'h41, MSB, 0, 0}, '{6, 5, 7, 0, 0}, '{6, MSB, 1, 0, 0}, '{6, ~MSB, ONES, 0, 0},
      '{6, 5, 7, 0, 1}, '{7, MSB, 1, 0, 1}, '{8, 5, 7, 0, 0}};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("reset resp", dss_word_t'(resp), '0);
    // back-to-back rows, answers compared two cycles behind
    for (int i = 0; i < N + 2; i++) begin
      @(posedge clk);
      if (i < N) drive(rows[i], i);
      else issue <= 1'b0;
      @(negedge clk);
      // the first two edges after release see no request yet
      if (i < 2) chk("idle flags", flags_of(resp), '0);
      if (i >= 2) cmp(rows[i-2], i - 2);
    end
    @(negedge clk);
    idleResp = '0;
    idleResp.destIndex = ~5'(N - 1);
    chk("idle resp", W'(resp), W'(idleResp));
    $display("table test done");
    // reset in mid-run swallows a pending request
    @(posedge clk);
    drive(rows[7], 7);
    rst <= 1'b1;
    @(posedge clk);
    issue <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk("mid reset resp", dss_word_t'(resp), '0);
    // release again and issue on the release edge; the unit takes it two edges later
    @(posedge clk);
    rst <= 1'b0;
    drive(rows[7], 7);
    @(negedge clk);
    chk("release resp", W'(resp), '0);
    @(posedge clk);
    issue <= 1'b0;
    @(negedge clk);
    chk("after release", flags_of(resp), '0);
    @(posedge clk);
    @(negedge clk);
    cmp(rows[7], 7);
    $display("reset test done");
    stop_test();
  end
endmodule
